/* File: logic/sync_serial_port_spi_status.sv */
/*
  Serial port in SPI mode with its status and control registers, reached
  over a classic Wishbone slave. Assumes pin inputs are asynchronous, the
  two-wire event inputs and the timer pulse come from same-clock logic.
*/
// Summary of operation
// - Each transfer shifts eight bits out and eight in simultaneously.
// - Pins: serial out, serial in, serial clock, optional slave select.
// - Slave with select control: select high resets the transfer logic.
// - Select high forces serial-out direction bit to read back set.
// - Master samples at end of output time if phase 1, else middle.
// - Clock edge bit picks stable edge; idle-high polarity reverses it.
// - Data/address flag shows kind of last two-wire byte.
// - Stop flag set by stop; cleared by reset, disable, later start.
// - Start flag set by start; cleared by reset, disable, later stop.
// - Read/write flag holds matched address direction until start/stop/ack.
// - Ten-bit two-wire mode sets the address refresh flag.
// - Buffer full while a byte waits or two-wire transmit runs.
// - Buffer write during a transfer sets collision; software clears it.
// - Mode field selects master rate or slave select behaviour.
// - Enable hands clock and data pins to the port.
// - Clock polarity sets the idle clock level.
// - Slave byte arriving on a full buffer sets overflow and is lost.
`timescale 1ns/1ps
`default_nettype none
`include "sync_serial_defs.svh"
module sync_serial_port_spi_status (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_o,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  input wire logic ss_n_i,
  input wire logic timer_pulse_i,
  input wire logic tw_start_i,
  input wire logic tw_stop_i,
  input wire logic tw_byte_i,
  input wire logic tw_byte_data_i,
  input wire logic tw_addr_match_i,
  input wire logic tw_rw_i,
  input wire logic tw_ack_i,
  input wire logic tw_addr_update_i,
  input wire logic tw_tx_busy_i
);
  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic sck_m, sck_s, sck_q, sdi_m, sdi_s, ssn_m, ssn_s;
  always_ff @(posedge clk_i) begin
    sck_m <= sck_i;
    sck_s <= sck_m;
    sck_q <= sck_s;
    sdi_m <= sdi_i;
    sdi_s <= sdi_m;
    ssn_m <= ss_n_i;
    ssn_s <= ssn_m;
  end

  ////////////////////////////////////////////////////////////////////////
  // State
  sync_serial_pkg::xfer_state_t state, next_state;
  logic [7:0] stat, next_stat, ctrl, next_ctrl, dir, next_dir;
  logic [7:0] buffer, next_buffer, sr, next_sr, slave_addr, next_slave_addr;
  logic [4:0] tick, next_tick;
  logic [3:0] nsamp, next_nsamp;
  logic [5:0] div, next_div;
  logic tog, next_tog, pif, next_pif, serial_out_pin, next_sdo;
  logic [31:0] next_dat;
  logic next_ack, next_sck, next_sck_oe, next_sdo_oe;
  logic acc, wr, rd, en, cke, input_sample_phase, master, slave, ss_hold, step;
  logic par, mid_e, end_e, samp, outp, done;
  logic [5:0] half;

  assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = acc && wb_we_i && wb_sel_i[0];
  assign rd = acc && !wb_we_i;
  assign en = ctrl[`CTRL_ENABLE];
  assign cke = stat[`STAT_CLOCK_EDGE];
  assign input_sample_phase = stat[`STAT_SAMPLE_PHASE];
  assign master = ctrl[3:0] <= `MODE_MASTER_TIMER;
  assign slave = ctrl[3:0] == `MODE_SLAVE_SELECT || ctrl[3:0] == `MODE_SLAVE_FREE;
  assign ss_hold = en && ctrl[3:0] == `MODE_SLAVE_SELECT && ssn_s;

  always_comb begin
    case (ctrl[3:0])
      `MODE_MASTER_DIV16: half = `HALF_DIV16;
      `MODE_MASTER_DIV64: half = `HALF_DIV64;
      default: half = `HALF_DIV4;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Shift engine and registers
  always_comb begin
    next_state = state;
    next_stat = stat;
    next_ctrl = ctrl;
    next_dir = dir;
    next_buffer = buffer;
    next_sr = sr;
    next_slave_addr = slave_addr;
    next_tick = tick;
    next_nsamp = nsamp;
    next_div = div;
    next_tog = tog;
    next_pif = pif;
    next_sdo = serial_out_pin;
    step = 1'b0;
    done = 1'b0;
    par = tick[0];
    mid_e = cke ? (!par && tick != `LAST_TICK) : par;
    end_e = cke ? par : (!par && tick != 5'h00);
    samp = 1'b0;
    outp = 1'b0;
    // Software writes first so hardware sets below win
    if (wr) begin
      case (wb_adr_i)
        `OFS_STATUS: next_stat[7:6] = wb_dat_i[7:6];
        `OFS_CONTROL: next_ctrl = wb_dat_i[7:0];
        `OFS_DIRECTION: next_dir = wb_dat_i[7:0];
        `OFS_IRQ_FLAG: next_pif = pif & wb_dat_i[0];
        `OFS_SLAVE_ADDR: begin
          next_slave_addr = wb_dat_i[7:0];
          next_stat[`STAT_ADDR_REFRESH] = 1'b0;
        end
        default: ;
      endcase
    end
    // Reading the buffer empties it
    if (rd && wb_adr_i == `OFS_BUFFER) next_stat[`STAT_BUFFER_FULL] = 1'b0;
    // Master steps on divider or timer pulse, slave on each pin clock edge
    if (master) begin
      if (state == sync_serial_pkg::st_run) begin
        if (ctrl[3:0] == `MODE_MASTER_TIMER) begin
          step = timer_pulse_i;
        end else if (div == half - 6'h01) begin
          step = 1'b1;
          next_div = 6'h00;
        end else begin
          next_div = div + 6'h01;
        end
      end
    end else begin
      step = slave && sck_s != sck_q;
    end
    // Disable or select high clears transfer
    if (!en || ss_hold) begin
      next_state = sync_serial_pkg::st_idle;
      next_tick = 5'h00;
      next_nsamp = 4'h0;
      next_tog = 1'b0;
      next_div = 6'h00;
    end else if (step) begin
      samp = input_sample_phase && master ? end_e : mid_e;
      outp = cke ? (par && tick < 5'h0f) : (!par && tick < 5'h0f);
      if (samp) begin
        next_sr = {sr[6:0], sdi_s};
        next_nsamp = nsamp + 4'h1;
      end
      if (outp) next_sdo = samp ? sr[6] : sr[7];
      if (master && tick < `LAST_TICK) next_tog = !tog;
      next_tick = tick + 5'h01;
      next_state = sync_serial_pkg::st_run;
      done = master ? tick == `LAST_TICK : samp && nsamp == 4'h7;
    end
    if (wr && wb_adr_i == `OFS_BUFFER) begin
      if (state == sync_serial_pkg::st_run) begin
        next_ctrl[`CTRL_COLLISION] = 1'b1;
      end else if (en) begin
        // Slave loads while deselected, ready before select falls
        next_sr = wb_dat_i[7:0];
        next_sdo = wb_dat_i[7];
        if (master) next_state = sync_serial_pkg::st_run;
      end
    end
    if (done) begin
      next_state = sync_serial_pkg::st_idle;
      next_tick = 5'h00;
      next_nsamp = 4'h0;
      next_tog = 1'b0;
      next_div = 6'h00;
      next_pif = 1'b1;
      // Slave byte lost on full buffer
      if (slave && stat[`STAT_BUFFER_FULL]) begin
        next_ctrl[`CTRL_OVERFLOW] = 1'b1;
      end else begin
        next_buffer = next_sr;
        next_stat[`STAT_BUFFER_FULL] = 1'b1;
      end
    end
    if (tw_byte_i) next_stat[`STAT_DATA_ADDR] = tw_byte_data_i;
    if (tw_start_i || tw_stop_i || tw_ack_i) next_stat[`STAT_READ_WRITE] = 1'b0;
    if (tw_addr_match_i) next_stat[`STAT_READ_WRITE] = tw_rw_i;
    if (tw_addr_update_i) next_stat[`STAT_ADDR_REFRESH] = 1'b1;
    if (tw_stop_i) begin
      next_stat[`STAT_STOP] = 1'b1;
      next_stat[`STAT_START] = 1'b0;
    end
    if (tw_start_i) begin
      next_stat[`STAT_START] = 1'b1;
      next_stat[`STAT_STOP] = 1'b0;
    end
    if (!next_ctrl[`CTRL_ENABLE]) next_stat[4:3] = 2'b00;
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus answer and pins
  always_comb begin
    next_dat = 32'h0000_0000;
    case (wb_adr_i)
      `OFS_STATUS: next_dat[7:0] = stat | {7'h00, tw_tx_busy_i};
      `OFS_CONTROL: next_dat[7:0] = ctrl;
      `OFS_BUFFER: next_dat[7:0] = buffer;
      `OFS_SLAVE_ADDR: next_dat[7:0] = slave_addr;
      // Select high reads serial-out bit as set
      `OFS_DIRECTION: next_dat[7:0] = dir | {3'h0, ss_hold, 4'h0};
      `OFS_IRQ_FLAG: next_dat[7:0] = {7'h00, pif};
      default: next_dat = 32'h0000_0000;
    endcase
    next_ack = acc;
    next_sck = next_ctrl[`CTRL_POLARITY] ^ next_tog;
    // Pins belong to port only when enabled
    next_sck_oe = next_ctrl[`CTRL_ENABLE] && next_ctrl[3:0] <= `MODE_MASTER_TIMER
      && !next_dir[`DIR_SERIAL_CLOCK];
    next_sdo_oe = next_ctrl[`CTRL_ENABLE] && !next_dir[`DIR_SERIAL_OUT] && !ss_hold
      && next_ctrl[3:0] <= `MODE_SLAVE_FREE;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= sync_serial_pkg::st_idle;
      stat <= `STATUS_RESET;
      ctrl <= `CONTROL_RESET;
      dir <= `DIRECTION_RESET;
      buffer <= 8'h00;
      sr <= 8'h00;
      slave_addr <= 8'h00;
      tick <= 5'h00;
      nsamp <= 4'h0;
      div <= 6'h00;
      tog <= 1'b0;
      pif <= 1'b0;
      serial_out_pin <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      wb_ack_o <= 1'b0;
      sck_o <= 1'b0;
      sck_oe_o <= 1'b0;
      sdo_o <= 1'b0;
      sdo_oe_o <= 1'b0;
    end else begin
      state <= next_state;
      stat <= next_stat;
      ctrl <= next_ctrl;
      dir <= next_dir;
      buffer <= next_buffer;
      sr <= next_sr;
      slave_addr <= next_slave_addr;
      tick <= next_tick;
      nsamp <= next_nsamp;
      div <= next_div;
      tog <= next_tog;
      pif <= next_pif;
      serial_out_pin <= next_sdo;
      wb_dat_o <= next_dat;
      wb_ack_o <= next_ack;
      sck_o <= next_sck;
      sck_oe_o <= next_sck_oe;
      sdo_o <= next_sdo;
      sdo_oe_o <= next_sdo_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sck_idle_a: assert property (
    en && master && state == sync_serial_pkg::st_idle && $past(tog) == 1'b0
    && $stable(ctrl) |-> sck_o == ctrl[`CTRL_POLARITY])
    else $error("clock not at idle level");
  collision_set_a: assert property (
    wr && wb_adr_i == `OFS_BUFFER && state == sync_serial_pkg::st_run
    |=> ctrl[`CTRL_COLLISION] && $stable(sr) == 1'b0 || ctrl[`CTRL_COLLISION])
    else $error("collision flag not set");
  done_flags_a: assert property (
    done && !slave |=> stat[`STAT_BUFFER_FULL] && pif && buffer == $past(next_sr))
    else $error("completion flags missing");
  overflow_keep_a: assert property (
    done && slave && stat[`STAT_BUFFER_FULL] && !rd
    |=> ctrl[`CTRL_OVERFLOW] && $stable(buffer))
    else $error("overflow not flagged");
  select_reset_a: assert property (
    ss_hold ##1 ss_hold |-> tick == 5'h00 && nsamp == 4'h0 && !sdo_oe_o)
    else $error("select high did not reset");
  dir_read_a: assert property (
    rd && wb_adr_i == `OFS_DIRECTION && ss_hold |=> wb_ack_o && wb_dat_o[4])
    else $error("direction bit not forced");
  start_last_a: assert property (
    tw_start_i && next_ctrl[`CTRL_ENABLE] |=> stat[`STAT_START] && !stat[`STAT_STOP])
    else $error("start flag wrong");
  stop_last_a: assert property (
    tw_stop_i && !tw_start_i && next_ctrl[`CTRL_ENABLE]
    |=> stat[`STAT_STOP] && !stat[`STAT_START])
    else $error("stop flag wrong");
  sample_count_a: assert property (
    done && master |-> nsamp + {3'h0, samp} == 4'h8)
    else $error("master byte not eight bits");
  master_length_a: assert property (
    disable iff (rst_i || !en || ctrl[3:0] != `MODE_MASTER_DIV4)
    state == sync_serial_pkg::st_idle ##1 state == sync_serial_pkg::st_run
    |-> ##[33:34] pif)
    else $error("fast master transfer length wrong");
  master_done_c: cover property (done && master);
  slave_done_c: cover property (done && slave && !stat[`STAT_BUFFER_FULL]);
  overflow_c: cover property (done && slave && stat[`STAT_BUFFER_FULL]);
  collision_c: cover property (wr && wb_adr_i == `OFS_BUFFER && state == sync_serial_pkg::st_run);
endmodule // sync_serial_port_spi_status
`default_nettype wire

/* File: logic/sync_serial_defs.svh */
/*
  Offsets, field positions, reset values and divider counts of the
  serial port. Assumes a 10 MHz system clock and byte-wide registers.
*/
`ifndef SYNC_SERIAL_DEFS_SVH
`define SYNC_SERIAL_DEFS_SVH
`define OFS_STATUS 8'h00
`define OFS_CONTROL 8'h04
`define OFS_BUFFER 8'h08
`define OFS_SLAVE_ADDR 8'h0c
`define OFS_DIRECTION 8'h10
`define OFS_IRQ_FLAG 8'h14
`define STAT_SAMPLE_PHASE 7
`define STAT_CLOCK_EDGE 6
`define STAT_DATA_ADDR 5
`define STAT_STOP 4
`define STAT_START 3
`define STAT_READ_WRITE 2
`define STAT_ADDR_REFRESH 1
`define STAT_BUFFER_FULL 0
`define CTRL_COLLISION 7
`define CTRL_OVERFLOW 6
`define CTRL_ENABLE 5
`define CTRL_POLARITY 4
`define DIR_SERIAL_OUT 4
`define DIR_SERIAL_CLOCK 6
`define STATUS_RESET 8'h00
`define CONTROL_RESET 8'h00
`define DIRECTION_RESET 8'hff
`define MODE_MASTER_DIV4 4'h0
`define MODE_MASTER_DIV16 4'h1
`define MODE_MASTER_DIV64 4'h2
`define MODE_MASTER_TIMER 4'h3
`define MODE_SLAVE_SELECT 4'h4
`define MODE_SLAVE_FREE 4'h5
`define HALF_DIV4 6'h02
`define HALF_DIV16 6'h08
`define HALF_DIV64 6'h20
`define LAST_TICK 5'h10
`endif

/* File: logic/sync_serial_pkg.sv */
/*
  Types of the serial port. Offsets and counts live in the defs header.
*/
package sync_serial_pkg;
  typedef enum logic {st_idle, st_run} xfer_state_t;
endpackage

/* File: verif/spi_far_end.sv */
/*
  Far end of the serial link: answers a master clock or makes one itself.
  Assumes the bench resolves the shared clock wire and sets pol first.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_far_end (
  input wire logic sck_i,
  input wire logic sdo_i,
  output logic sdi_o,
  output logic sck_o,
  output logic ss_n_o
);
  logic pol = 1'b0;
  logic [7:0] tx = 8'h00;
  logic [7:0] rx = 8'h00;
  initial begin
    sck_o = 1'b0;
    ss_n_o = 1'b1;
  end
  assign sdi_o = tx[7];
  always @(posedge sck_i or negedge sck_i) begin
    if (sck_i ^ pol) begin
      rx <= {rx[6:0], sdo_i};
    end else begin
      // Spent bits become a changing pattern, never a held value
      tx <= {tx[6:0], ~tx[0]};
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // framed 800 ns clock
  task automatic frame(input logic [7:0] b);
    tx = b;
    sck_o = pol;
    #37 ss_n_o = 1'b0;
    #400;
    repeat (8) begin
      sck_o = ~pol;
      #400 sck_o = pol;
      #400;
    end
    ss_n_o = 1'b1;
  endtask
endmodule // spi_far_end
`default_nettype wire

/* File: verif/tb_sync_serial_port_spi_status.sv */
/*
  Self-checking bench: bus registers, master and slave transfers and the
  two-wire status flags. Assumes the far-end model beside the port.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sync_serial_defs.svh"
module tb_sync_serial_port_spi_status;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack, sck_o, sck_oe_o, sdo_o, sdo_oe_o, far_sck, serial_in_pin, ss_n;
  logic timer = 1'b0;
  logic [1:0] tcnt = 2'h0;
  // Start, stop, byte, match, ack, update
  logic [5:0] ev = 6'h00;
  logic byte_data = 1'b0;
  logic rw = 1'b0;
  logic busy = 1'b0;
  logic [7:0] q;
  int bad_count = 0;
  int num_checks = 0;
  wire logic sck_w;
  assign sck_w = sck_oe_o ? sck_o : far_sck;
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    tcnt <= (tcnt == 2'h2) ? 2'h0 : tcnt + 2'h1;
    timer <= (tcnt == 2'h2);
  end
  sync_serial_port_spi_status dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .sck_i(sck_w), .sck_o(sck_o), .sck_oe_o(sck_oe_o),
    .sdi_i(serial_in_pin), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .ss_n_i(ss_n), .timer_pulse_i(timer),
    .tw_start_i(ev[0]), .tw_stop_i(ev[1]), .tw_byte_i(ev[2]), .tw_byte_data_i(byte_data),
    .tw_addr_match_i(ev[3]), .tw_rw_i(rw), .tw_ack_i(ev[4]), .tw_addr_update_i(ev[5]),
    .tw_tx_busy_i(busy));
  spi_far_end far (.sck_i(sck_w), .sdo_i(sdo_o), .sdi_o(serial_in_pin), .sck_o(far_sck), .ss_n_o(ss_n));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s: got %h want %h", $time, msg, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    // Ends on ack; with no ack only the watchdog ends this wait
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string msg);
    wb(1'b0, a, 8'h00);
    chk(q, exp, msg);
  endtask
  task automatic poll(input logic [7:0] a, input int b);
    int n;
    n = 0;
    do begin
      wb(1'b0, a, 8'h00);
      n++;
    end while (q[b] !== 1'b1 && n < 300);
    if (q[b] !== 1'b1) begin
      bad_count++;
      $display("[FAIL] %0t poll limit reached", $time);
    end
  endtask
  task automatic pulse(input int i);
    @(posedge clk_i);
    ev[i] <= 1'b1;
    @(posedge clk_i);
    ev[i] <= 1'b0;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(`OFS_STATUS, `STATUS_RESET, "status reset");
    rd(`OFS_CONTROL, `CONTROL_RESET, "control reset");
    rd(`OFS_DIRECTION, `DIRECTION_RESET, "direction reset");
    wb(1'b1, 8'h20, 8'h5a);
    rd(8'h20, 8'h00, "unmapped reads zero");
    chk({6'h0, sck_oe_o, sdo_oe_o}, 8'h00, "pins free at reset");
    $display("reset test done");
  endtask
  task automatic xfer(input logic [3:0] m, input logic p, input logic ph,
                      input logic [7:0] tx, input logic [7:0] ptx);
    int h;
    realtime t0;
    h = (m == 4'h0) ? 2 : (m == 4'h1) ? 8 : (m == 4'h2) ? 32 : 3;
    wb(1'b1, `OFS_CONTROL, {3'b001, p, m});
    wb(1'b1, `OFS_STATUS, {ph, 7'h40});
    wb(1'b1, `OFS_DIRECTION, 8'haf);
    far.pol = p;
    far.tx = ptx;
    chk({7'h0, sck_w}, {7'h0, p}, "idle clock level");
    t0 = $realtime;
    wb(1'b1, `OFS_BUFFER, tx);
    wb(1'b1, `OFS_BUFFER, 8'h11);
    poll(`OFS_STATUS, 0);
    // Seventeen steps of one half period, plus bus and poll slack
    h = int'(($realtime - t0) / 100.0) - 17 * h + 3;
    chk({7'h0, h >= 0 && h <= 15}, 8'h01, "transfer length");
    rd(`OFS_CONTROL, {3'b101, p, m}, "collision set");
    rd(`OFS_IRQ_FLAG, 8'h01, "port flag set");
    rd(`OFS_BUFFER, ptx, "received byte");
    rd(`OFS_STATUS, {ph, 7'h40}, "full cleared by read");
    chk(far.rx, tx, "sent byte msb first");
    wb(1'b1, `OFS_CONTROL, {3'b001, p, m});
    rd(`OFS_CONTROL, {3'b001, p, m}, "collision cleared");
    wb(1'b1, `OFS_IRQ_FLAG, 8'h00);
    chk({7'h0, sck_w}, {7'h0, p}, "clock back at idle");
    $display("master transfer mode %0d done", m);
  endtask
  task automatic t_slave();
    wb(1'b1, `OFS_CONTROL, {4'h2, `MODE_SLAVE_SELECT});
    wb(1'b1, `OFS_STATUS, 8'h40);
    wb(1'b1, `OFS_DIRECTION, 8'hef);
    far.pol = 1'b0;
    rd(`OFS_DIRECTION, 8'hff, "out bit set, select high");
    chk({7'h0, sdo_oe_o}, 8'h00, "no drive, select high");
    wb(1'b1, `OFS_BUFFER, 8'h96);
    far.frame(8'h69);
    poll(`OFS_STATUS, 0);
    chk(far.rx, 8'h96, "slave sent byte");
    far.frame(8'h3c);
    poll(`OFS_CONTROL, 6);
    rd(`OFS_CONTROL, 8'h64, "overflow on full buffer");
    rd(`OFS_BUFFER, 8'h69, "new byte lost");
    wb(1'b1, `OFS_CONTROL, 8'h00);
    chk({6'h0, sck_oe_o, sdo_oe_o}, 8'h00, "pins freed on disable");
    $display("slave test done");
  endtask
  task automatic t_twowire();
    wb(1'b1, `OFS_STATUS, 8'h00);
    wb(1'b1, `OFS_CONTROL, 8'h20);
    pulse(0);
    rd(`OFS_STATUS, 8'h08, "start last");
    pulse(1);
    rd(`OFS_STATUS, 8'h10, "stop last");
    byte_data <= 1'b1;
    pulse(2);
    rd(`OFS_STATUS, 8'h30, "data byte");
    byte_data <= 1'b0;
    pulse(2);
    rd(`OFS_STATUS, 8'h10, "address byte");
    rw <= 1'b1;
    pulse(3);
    rd(`OFS_STATUS, 8'h14, "read direction");
    pulse(5);
    rd(`OFS_STATUS, 8'h16, "address refresh");
    wb(1'b1, `OFS_SLAVE_ADDR, 8'h50);
    busy <= 1'b1;
    rd(`OFS_STATUS, 8'h15, "refresh cleared, busy full");
    busy <= 1'b0;
    pulse(4);
    rd(`OFS_STATUS, 8'h10, "ack clears direction");
    pulse(0);
    wb(1'b1, `OFS_CONTROL, 8'h00);
    wb(1'b0, `OFS_STATUS, 8'h00);
    chk(q & 8'h18, 8'h00, "start cleared on disable");
    $display("two-wire test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    for (int m = 0; m < 4; m++) begin
      // Fastest rate samples at end: middle sampling outruns the pin synchroniser
      xfer(m[3:0], 1'b0, m == 0, 8'h3c + m[7:0], 8'ha5 - m[7:0]);
    end
    xfer(4'h1, 1'b1, 1'b0, 8'hc3, 8'h5a);
    t_slave();
    t_twowire();
    test_done();
  end
  // Whole run needs some 1400 cycles
  initial begin
    #2000000;
    bad_count++;
    test_done();
  end
endmodule // tb_sync_serial_port_spi_status
`default_nettype wire
